// *** rtl/ddrio_pkg.sv ***
// Shared constants and types of the double-rate I/O element.
package ddrio_pkg;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    DDRIO_MODE_IN    = 3'h1,
    DDRIO_MODE_OUT   = 3'h2,
    DDRIO_MODE_BIDIR = 3'h4
  } ddrio_mode_t;

  // ****************************************************************
  // Boundary inversion mask bit positions
  // ****************************************************************
  localparam int INV_W        = 7;
  localparam int INV_CLK      = 0;
  localparam int INV_DOUT_HI  = 1;
  localparam int INV_DOUT_LO  = 2;
  localparam int INV_OE       = 3;
  localparam int INV_CE_IN    = 4;
  localparam int INV_CE_OUT   = 5;
  localparam int INV_SCLR     = 6;

  // ****************************************************************
  // Strobe groups and phase reference
  // ****************************************************************
  localparam int GROUPS_PER_EDGE = 18;
  localparam int GROUPS_RIGHT    = 10;
  localparam int GROUPS_LEFT     = 8;
  localparam int GROUP_IDX_W     = 5;
  localparam logic [2:0] PLL_TOP    = 3'h5;
  localparam logic [2:0] PLL_BOTTOM = 3'h6;
  localparam int DELAY_W          = 6;
  localparam logic [5:0] DELAY_CODE_RESET = 6'h00;
  localparam logic [5:0] DELAY_CODE_NOM   = 6'h10;

  // ****************************************************************
  // Legal data widths per strobe group
  // ****************************************************************
  localparam int WIDTH_X4  = 4;
  localparam int WIDTH_X8  = 8;
  localparam int WIDTH_X9  = 9;
  localparam int WIDTH_X16 = 16;
  localparam int WIDTH_X18 = 18;
  localparam int WIDTH_X32 = 32;
  localparam int WIDTH_X36 = 36;

endpackage : ddrio_pkg

// *** rtl/ddrio_phase_ref.sv ***
// Phase reference controller that sets strobe delay codes for one edge.
module ddrio_phase_ref
  import ddrio_pkg::*;
(
  input  wire logic                            mclk,
  input  wire logic                            reset,
  input  wire logic                            isTopEdge,
  input  wire logic                            refFromPll,
  input  wire logic [2:0]                      pllIndex,
  input  wire logic                            refLock,
  input  wire logic                            groupOnTopEdge,
  output logic      [ddrio_pkg::DELAY_W-1:0]   delayCode,
  output logic                                 refValid
);

  // ****************************************************************
  // Reference checks
  // ****************************************************************
  logic lockMeta;
  logic lockSync;
  logic next_refValid;
  wire  pllAllowed;
  wire  sameEdge;

  // Only the edge's own PLL may act as reference.
  assign pllAllowed = isTopEdge ? (pllIndex == PLL_TOP)
                                : (pllIndex == PLL_BOTTOM);
  // A controller serves strobe pins of its own edge only.
  assign sameEdge = (groupOnTopEdge == isTopEdge);
  assign next_refValid = lockSync && sameEdge
                         && (!refFromPll || pllAllowed);

  // Lock level comes from the reference clock domain.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
    end else begin
      lockMeta <= refLock;
      lockSync <= lockMeta;
    end
  end

  // The delay code is applied only under a valid reference.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      refValid  <= 1'b0;
      delayCode <= DELAY_CODE_RESET;
    end else begin
      refValid  <= next_refValid;
      delayCode <= next_refValid ? DELAY_CODE_NOM : DELAY_CODE_RESET;
    end
  end

  property p_pll_check;
    @(posedge mclk) disable iff (reset)
      (refFromPll && !pllAllowed) |=> !refValid;
  endproperty
  a_pll_check : assert property (p_pll_check)
    else $error("Wrong PLL accepted as phase reference.");

  property p_edge_only;
    @(posedge mclk) disable iff (reset)
      !sameEdge |=> (delayCode == DELAY_CODE_RESET);
  endproperty
  a_edge_only : assert property (p_edge_only)
    else $error("Delay code set for a group on the other edge.");

endmodule : ddrio_phase_ref

// *** rtl/ddrio_element.sv ***
// Double-rate I/O element for one pin with strobe-clocked capture.
module ddrio_element
  import ddrio_pkg::*;
#(
  parameter ddrio_pkg::ddrio_mode_t MODE = ddrio_pkg::DDRIO_MODE_BIDIR,
  parameter logic [ddrio_pkg::INV_W-1:0] INVERT_MASK = '0,
  parameter bit   POWER_UP_HIGH = 1'b0,
  parameter int   GROUP_WIDTH   = ddrio_pkg::WIDTH_X8,
  parameter int   GROUP_INDEX   = 0,
  parameter bit   TOP_EDGE      = 1'b1
)
(
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          strobeClk,
  input  wire logic                          dataOutHi,
  input  wire logic                          dataOutLo,
  input  wire logic                          oeRequest,
  input  wire logic                          ceIn,
  input  wire logic                          ceOut,
  input  wire logic                          syncClear,
  input  wire logic                          padIn,
  output logic                               padOut,
  output logic                               padOe_n,
  output logic                               dataInRise,
  output logic                               dataInFall,
  output logic                               strobeDataRise,
  output logic                               strobeDataFall,
  output logic                               strobeDataValid,
  input  wire logic                          refFromPll,
  input  wire logic [2:0]                    pllIndex,
  input  wire logic                          refLock,
  output logic [ddrio_pkg::DELAY_W-1:0]      strobeDelayTap,
  output logic                               strobeRefValid,
  output logic                               groupWidthOk,
  output logic                               groupOnRight
);

  // ****************************************************************
  // Boundary inversion and static configuration
  // ****************************************************************
  localparam logic PU = POWER_UP_HIGH;
  wire ioClk;
  wire dHi;
  wire dLo;
  wire oeReq;
  wire ceI;
  wire ceO;
  wire sClr;
  wire outUsed;
  wire inUsed;
  wire bidir;

  // Each core-side input (clock, data, enable request, clock enables, sync clear) may be flipped at the element edge.
  assign ioClk = mclk      ^ INVERT_MASK[INV_CLK];
  assign dHi   = dataOutHi ^ INVERT_MASK[INV_DOUT_HI];
  assign dLo   = dataOutLo ^ INVERT_MASK[INV_DOUT_LO];
  assign oeReq = oeRequest ^ INVERT_MASK[INV_OE];
  assign ceI   = ceIn      ^ INVERT_MASK[INV_CE_IN];
  assign ceO   = ceOut     ^ INVERT_MASK[INV_CE_OUT];
  assign sClr  = syncClear ^ INVERT_MASK[INV_SCLR];
  assign bidir   = (MODE == DDRIO_MODE_BIDIR);
  assign outUsed = (MODE == DDRIO_MODE_OUT) || bidir;
  assign inUsed  = (MODE == DDRIO_MODE_IN)  || bidir;

  // Only the documented group widths are legal.
  assign groupWidthOk = (GROUP_WIDTH == WIDTH_X4)
                     || (GROUP_WIDTH == WIDTH_X8)
                     || (GROUP_WIDTH == WIDTH_X9)
                     || (GROUP_WIDTH == WIDTH_X16)
                     || (GROUP_WIDTH == WIDTH_X18)
                     || (GROUP_WIDTH == WIDTH_X32)
                     || (GROUP_WIDTH == WIDTH_X36);
  // Group indices below ten sit right of the controller, rest left.
  assign groupOnRight = (GROUP_INDEX < GROUPS_RIGHT);

  // ****************************************************************
  // Output path: two rising-edge registers and the clock mux
  // ****************************************************************
  logic txHi;
  logic txLo;
  wire  next_txHi;
  wire  next_txLo;

  // Clock enable low holds; sync clear forces the power-up level.
  assign next_txHi = sClr ? PU : (ceO ? dHi : txHi);
  assign next_txLo = sClr ? PU : (ceO ? dLo : txLo);

  // Both data paths load together on the rising edge.
  always_ff @(posedge ioClk or posedge reset) begin
    if (reset) begin
      txHi <= PU;
      txLo <= PU;
    end else begin
      txHi <= next_txHi;
      txLo <= next_txLo;
    end
  end

  // High phase shows the first bit, low phase the second.
  assign padOut = ioClk ? txHi : txLo;

  // ****************************************************************
  // Output enable: one rising and one falling edge register
  // ****************************************************************
  logic oeRise_n;
  logic oeFall_n;
  wire  next_oeRise_n;

  // Request is active high, the driver enable active low.
  assign next_oeRise_n = sClr ? 1'b1
                       : (ceO ? ~(oeReq && outUsed) : oeRise_n);

  // Same clock and enable as the output data registers.
  always_ff @(posedge ioClk or posedge reset) begin
    if (reset) begin
      oeRise_n <= 1'b1;
    end else begin
      oeRise_n <= next_oeRise_n;
    end
  end

  // Falling-edge copy delays the enable by half a cycle.
  always_ff @(negedge ioClk or posedge reset) begin
    if (reset) begin
      oeFall_n <= 1'b1;
    end else begin
      oeFall_n <= oeRise_n;
    end
  end

  assign padOe_n = bidir ? oeFall_n : oeRise_n;

  // ****************************************************************
  // Input path: two capture registers and the aligning stage
  // ****************************************************************
  logic rxRise;
  logic rxFall;
  logic rxHold;
  wire  capEn;

  assign capEn = ceI && inUsed;

  // Rising-edge capture register.
  always_ff @(posedge ioClk or posedge reset) begin
    if (reset) begin
      rxRise <= PU;
    end else if (sClr) begin
      rxRise <= PU;
    end else if (capEn) begin
      rxRise <= padIn;
    end
  end

  // Falling-edge capture register.
  always_ff @(negedge ioClk or posedge reset) begin
    if (reset) begin
      rxFall <= PU;
    end else if (sClr) begin
      rxFall <= PU;
    end else if (capEn) begin
      rxFall <= padIn;
    end
  end

  // Holds the high-phase bit so both bits leave on one edge.
  always_ff @(negedge ioClk or posedge reset) begin
    if (reset) begin
      rxHold <= PU;
    end else if (capEn) begin
      rxHold <= rxRise;
    end
  end

  // Both bits presented together on the rising edge.
  always_ff @(posedge ioClk or posedge reset) begin
    if (reset) begin
      dataInRise <= PU;
      dataInFall <= PU;
    end else if (capEn) begin
      dataInRise <= rxHold;
      dataInFall <= rxFall;
    end
  end

  // ****************************************************************
  // Phase reference and strobe delay
  // ****************************************************************
  logic [DELAY_W-1:0] delayCode;
  logic [DELAY_W-1:0] tapMeta;

  ddrio_phase_ref u_phase_ref (
    .mclk           (mclk),
    .reset          (reset),
    .isTopEdge      (TOP_EDGE),
    .refFromPll     (refFromPll),
    .pllIndex       (pllIndex),
    .refLock        (refLock),
    .groupOnTopEdge (TOP_EDGE),
    .delayCode      (delayCode),
    .refValid       (strobeRefValid)
  );

  // The tap setting is quasi-static and crosses as a level.
  always_ff @(posedge strobeClk or posedge reset) begin
    if (reset) begin
      tapMeta        <= DELAY_CODE_RESET;
      strobeDelayTap <= DELAY_CODE_RESET;
    end else begin
      tapMeta        <= delayCode;
      strobeDelayTap <= tapMeta;
    end
  end

  // ****************************************************************
  // Strobe-clocked capture and crossing back to the I/O clock
  // ****************************************************************
  logic sRise;
  logic sWordRise;
  logic sWordFall;
  logic sToggle;
  logic ackMeta;
  logic ackSync;
  logic tMeta;
  logic tSync;
  logic tSeen;
  wire  sIdle;
  wire  newWord;

  // Delayed strobe bus clocks the group's rising capture register.
  always_ff @(posedge strobeClk or posedge reset) begin
    if (reset) begin
      sRise <= 1'b0;
    end else begin
      sRise <= padIn;
    end
  end

  // A word is posted only after the previous one was taken, so the
  // I/O clock side never reads a word that is still moving.
  assign sIdle = (sToggle == ackSync);

  // Falling strobe edge pairs this cycle's two bits and announces them.
  always_ff @(negedge strobeClk or posedge reset) begin
    if (reset) begin
      sWordRise <= 1'b0;
      sWordFall <= 1'b0;
      sToggle   <= 1'b0;
    end else if (sIdle) begin
      sWordRise <= sRise;
      sWordFall <= padIn;
      sToggle   <= ~sToggle;
    end
  end

  // The take acknowledge returns to the strobe domain.
  always_ff @(negedge strobeClk or posedge reset) begin
    if (reset) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end else begin
      ackMeta <= tSeen;
      ackSync <= ackMeta;
    end
  end

  assign newWord = tSync ^ tSeen;

  // Toggle synchroniser, then the stable word is taken.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tMeta           <= 1'b0;
      tSync           <= 1'b0;
      tSeen           <= 1'b0;
      strobeDataRise  <= 1'b0;
      strobeDataFall  <= 1'b0;
      strobeDataValid <= 1'b0;
    end else begin
      tMeta           <= sToggle;
      tSync           <= tMeta;
      tSeen           <= tSync;
      strobeDataValid <= newWord;
      if (newWord) begin
        strobeDataRise <= sWordRise;
        strobeDataFall <= sWordFall;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_load;
    !sClr && ceO;
  endsequence

  sequence s_oe_late;
    padOe_n ##1 !padOe_n;
  endsequence

  property p_out_load;
    bit hi;
    @(posedge ioClk) disable iff (reset)
      (s_load, hi = dHi) |=> (txHi == hi);
  endproperty
  a_out_load : assert property (p_out_load)
    else $error("Output register missed its rising-edge load.");

  property p_hold;
    @(posedge ioClk) disable iff (reset)
      (!sClr && !ceO) |=> $stable(txHi) && $stable(txLo);
  endproperty
  a_hold : assert property (p_hold)
    else $error("Output register changed with enable low.");

  // Sampled at the end of the high phase, the pin shows the first bit.
  property p_mux_high;
    @(negedge ioClk) disable iff (reset)
      1'b1 |-> (padOut == txHi);
  endproperty
  a_mux_high : assert property (p_mux_high)
    else $error("High phase does not show the first bit.");

  // Sampled at the end of the low phase, the pin shows the second bit.
  property p_mux_rise;
    @(posedge ioClk) disable iff (reset)
      1'b1 |-> (padOut == txLo);
  endproperty
  a_mux_rise : assert property (p_mux_rise)
    else $error("Low phase does not show the second bit.");

  property p_oe_low;
    @(posedge ioClk) disable iff (reset)
      (!sClr && ceO && oeReq && outUsed) |=> !oeRise_n;
  endproperty
  a_oe_low : assert property (p_oe_low)
    else $error("Enable request did not drive the pin.");

  // The pin enable trails the rising register by one falling edge.
  property p_oe_neg;
    @(negedge ioClk) disable iff (reset)
      (bidir && $fell(oeRise_n)) |-> s_oe_late;
  endproperty
  a_oe_neg : assert property (p_oe_neg)
    else $error("Enable went active before the falling edge.");

  property p_in_align;
    @(posedge ioClk) disable iff (reset)
      (capEn && $past(capEn) && !sClr) |=> (dataInFall == $past(rxFall));
  endproperty
  a_in_align : assert property (p_in_align)
    else $error("Falling bit not aligned to the rising edge.");

  property p_sclr;
    @(posedge ioClk) disable iff (reset)
      sClr |=> (txHi == PU) && (txLo == PU) && padOe_n;
  endproperty
  a_sclr : assert property (p_sclr)
    else $error("Synchronous clear missed the power-up level.");

  property p_cross;
    @(posedge mclk) disable iff (reset)
      newWord |=> strobeDataValid && (strobeDataRise == $past(sWordRise));
  endproperty
  a_cross : assert property (p_cross)
    else $error("Strobe word not taken on the announced cycle.");

endmodule : ddrio_element

// *** bench/ddrio_memory_model.sv ***
// Behavioural memory device on the far side of the double-rate pin.
module ddrio_memory_model (
  input  wire logic mclk,
  input  wire logic txRise,
  input  wire logic txFall,
  input  wire logic padOe_n,
  output logic      memLevel,
  output logic      strobeClk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic fallHeld;

  // ****************************************************************
  // Data driver
  // ****************************************************************
  // Everything starts idle, with the strobe standing low.
  initial begin
    memLevel  = 1'h0;
    strobeClk = 1'h0;
    fallHeld  = 1'h0;
  end

  // The rise bit settles in the low phase, clear of the rising edge.
  // While the element drives, the released line shows a moving level.
  always @(negedge mclk) begin
    fallHeld <= txFall;
    #4 memLevel = padOe_n ? txRise : ~memLevel;
  end

  // The fall bit settles in the high phase, clear of the falling edge.
  always @(posedge mclk) begin
    #4 memLevel = padOe_n ? fallHeld : ~memLevel;
  end

  // ****************************************************************
  // Strobe bursts
  // ****************************************************************
  // The strobe runs only inside a burst, at one fixed period.
  task automatic burst(input int cycles);
    #3.3;
    repeat (cycles) begin
      strobeClk = 1'h1;
      #7.5;
      strobeClk = 1'h0;
      #7.5;
    end
  endtask : burst

endmodule : ddrio_memory_model

// *** bench/test_ddr_io_element_with_strobe_capture.sv ***
// Self-checking bench of the double-rate I/O element.
module test_ddr_io_element_with_strobe_capture
  import ddrio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk, reset, dataOutHi, dataOutLo, oeRequest;
  logic       ceIn, ceOut, syncClear, refFromPll, refLock;
  logic [2:0] pllIndex;
  logic       txRise, txFall, chkIn;
  logic       eHi, eLo, oeT, eOe_n, rxR, lat, rxF, eR, eF;
  wire        strobeClk, memLevel, padIn, padOut, padOe_n;
  wire        dataInRise, dataInFall, strobeDataRise, strobeDataFall;
  wire        strobeDataValid, strobeRefValid, groupWidthOk, groupOnRight;
  wire  [5:0] strobeDelayTap;
  int         fails, checks;

  // ****************************************************************
  // Clock, pin and instances
  // ****************************************************************
  // The I/O clock toggles every half period.
  always #12.5 mclk = ~mclk;

  // The pin follows the element while it drives, else the memory.
  assign padIn = padOe_n ? memLevel : padOut;

  ddrio_element #(.MODE(DDRIO_MODE_BIDIR), .GROUP_WIDTH(WIDTH_X8)) i_dut (
    .mclk(mclk), .reset(reset), .strobeClk(strobeClk),
    .dataOutHi(dataOutHi), .dataOutLo(dataOutLo),
    .oeRequest(oeRequest), .ceIn(ceIn), .ceOut(ceOut),
    .syncClear(syncClear), .padIn(padIn), .padOut(padOut),
    .padOe_n(padOe_n), .dataInRise(dataInRise),
    .dataInFall(dataInFall), .strobeDataRise(strobeDataRise),
    .strobeDataFall(strobeDataFall), .strobeDataValid(strobeDataValid),
    .refFromPll(refFromPll), .pllIndex(pllIndex), .refLock(refLock),
    .strobeDelayTap(strobeDelayTap), .strobeRefValid(strobeRefValid),
    .groupWidthOk(groupWidthOk), .groupOnRight(groupOnRight));

  ddrio_memory_model i_mem (.mclk(mclk), .txRise(txRise),
    .txFall(txFall), .padOe_n(padOe_n), .memLevel(memLevel),
    .strobeClk(strobeClk));

  // ****************************************************************
  // Reference model
  // ****************************************************************
  // Rising-edge registers: output pair, enable request, input stages.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      {eHi, eLo, oeT, rxR, eR, eF} <= '0;
    end else if (syncClear) begin
      {eHi, eLo, oeT, rxR, eR, eF} <= '0;
    end else begin
      if (ceOut) {eHi, eLo, oeT} <= {dataOutHi, dataOutLo, oeRequest};
      if (ceIn) {rxR, eR, eF} <= {padIn, lat, rxF};
    end
  end

  // Falling-edge stages: the enable register, the latch, the fall bit.
  always @(negedge mclk or posedge reset) begin
    if (reset) begin
      {lat, rxF} <= 2'h0;
      eOe_n <= 1'h1;
    end else begin
      eOe_n <= ~oeT;
      if (ceIn) {lat, rxF} <= {rxR, padIn};
    end
  end

  // ****************************************************************
  // Compare and closing tasks
  // ****************************************************************
  // Single-bit results.
  task automatic cmpBit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : cmpBit

  // Delay tap results.
  task automatic cmpTap(input string what, input logic [5:0] e,
                        input logic [5:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmpTap

  // Prints the verdict and ends the run.
  task automatic results();
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // ****************************************************************
  // Scenario tasks
  // ****************************************************************
  // One clock of traffic; pin checked in both phases of the cycle.
  task automatic step(input logic hi, lo, oe, cei, ceo, sc);
    @(posedge mclk);
    #2;
    {dataOutHi, dataOutLo, oeRequest} = {hi, lo, oe};
    {ceIn, ceOut, syncClear} = {cei, ceo, sc};
    txRise = 1'($urandom);
    txFall = 1'($urandom);
    #8;
    cmpBit("padOut high", eHi, padOut);
    cmpBit("padOe_n high", eOe_n, padOe_n);
    if (chkIn) begin
      cmpBit("dataInRise", eR, dataInRise);
      cmpBit("dataInFall", eF, dataInFall);
    end
    @(negedge mclk);
    #10;
    cmpBit("padOut low", eLo, padOut);
    cmpBit("padOe_n low", eOe_n, padOe_n);
  endtask : step

  // Constant pin level, one strobe burst, then the word in mclk.
  task automatic strobeWord(input logic v);
    int n;
    repeat (10) @(posedge mclk);
    #2;
    {txRise, txFall} = {v, v};
    repeat (3) @(posedge mclk);
    fork
      i_mem.burst(6);
    join_none
    n = 0;
    while (strobeDataValid !== 1'h1 && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmpBit("strobeDataValid", 1'h1, strobeDataValid);
    cmpBit("strobeDataRise", v, strobeDataRise);
    cmpBit("strobeDataFall", v, strobeDataFall);
  endtask : strobeWord

  // Reference selection, then a burst to carry the tap across.
  task automatic phaseCase(input logic pll, input logic [2:0] idx,
                           input logic lock);
    logic ok;
    @(posedge mclk);
    #2;
    {refFromPll, pllIndex, refLock} = {pll, idx, lock};
    ok = lock && (!pll || idx == PLL_TOP);
    repeat (6) @(posedge mclk);
    i_mem.burst(4);
    #5;
    cmpBit("strobeRefValid", ok, strobeRefValid);
    cmpTap("strobeDelayTap", ok ? DELAY_CODE_NOM : DELAY_CODE_RESET,
           strobeDelayTap);
  endtask : phaseCase

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  // Reset, output traffic, input traffic, strobe words, phase cases.
  initial begin
    void'($urandom(82010));
    {mclk, dataOutHi, dataOutLo, oeRequest, ceIn, ceOut} = '0;
    {syncClear, refFromPll, refLock, txRise, txFall, chkIn} = '0;
    pllIndex = 3'h0;
    fails = 0;
    checks = 0;
    reset = 1'h1;
    fork
      i_mem.burst(3);
    join_none
    repeat (4) @(posedge mclk);
    cmpBit("padOe_n reset", 1'h1, padOe_n);
    cmpBit("dataInRise reset", 1'h0, dataInRise);
    cmpTap("tap reset", DELAY_CODE_RESET, strobeDelayTap);
    cmpBit("groupWidthOk", 1'h1, groupWidthOk);
    cmpBit("groupOnRight", 1'h1, groupOnRight);
    #2 reset = 1'h0;
    repeat (40) step(1'($urandom), 1'($urandom), 1'($urandom), 1'h0,
      $urandom_range(3) != 0, $urandom_range(15) == 0);
    repeat (3) step(1'($urandom), 1'($urandom), 1'h0, 1'h1, 1'h1, 1'h0);
    chkIn = 1'h1;
    repeat (40) step(1'($urandom), 1'($urandom), 1'h0, 1'h1, 1'h1,
      1'h0);
    chkIn = 1'h0;
    strobeWord(1'h0);
    strobeWord(1'h1);
    for (int i = 0; i < 8; i++) phaseCase(1'h1, 3'(i), 1'h1);
    phaseCase(1'h0, 3'h2, 1'h1);
    phaseCase(1'h0, 3'h5, 1'h0);
    results();
  end

  // Cuts a hang short well past the expected run time.
  initial begin
    #200000;
    fails++;
    results();
  end

endmodule : test_ddr_io_element_with_strobe_capture
